// >>> core/relay_link_pkg.sv
/*
  constants, register map and helpers shared by both ends of the relay
  output serial link.
  assumes a 100 mhz core clock on each end; the link clock comes from the
  host end.
*/
package relay_link_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CORE_PERIOD_NS = 10;
  localparam int unsigned REFRESH_US = 100;
  localparam int unsigned REFRESH_CYCLES =
    (REFRESH_US * 1000) / CORE_PERIOD_NS;
  // serial clock rate and the host-side delays, rounded up to cycles
  localparam int unsigned LINK_FREQ_KHZ = 4000;
  localparam int unsigned LINK_HALF_NS = 1000000 / (2 * LINK_FREQ_KHZ);
  localparam int unsigned LINK_HALF_CYCLES =
    (LINK_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned SCLK_PULSE_MIN_NS = 60;
  localparam int unsigned SCLK_PULSE_MIN_CYCLES =
    (SCLK_PULSE_MIN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned LEAD_NS = 80;
  localparam int unsigned LEAD_CYCLES =
    (LEAD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned FIRST_RISE_NS = 10;
  localparam int unsigned FIRST_RISE_CYCLES =
    (FIRST_RISE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned TAIL_NS = 80;
  localparam int unsigned TAIL_CYCLES =
    (TAIL_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned GAP_NS = 170;
  localparam int unsigned GAP_CYCLES =
    (GAP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int unsigned PWM_MAX_HZ = 5000;

  // ****************************************************************
  // word format
  // ****************************************************************
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned CHANNEL_ONE_BIT = 0;
  localparam int unsigned CHANNEL_EIGHT_BIT = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int unsigned EDGE_COUNT_W = 5;
  localparam logic [4:0] WORD_EDGES = 5'h08;

  // ****************************************************************
  // host register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] TX_WORD_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned REFUSED_BIT = 1;

  function automatic logic [4:0] gray_to_bin(input logic [4:0] g);
    logic [4:0] b;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [4:0] bin_to_gray(input logic [4:0] b);
    return b ^ (b >> 1);
  endfunction

endpackage

// >>> core/relay_link_if.sv
/*
  the three wires between the host controller and the relay output device.
  assumes the bench or a top connects one host and one device.
*/
interface relay_link_if;
  logic sclk; // serial clock, made by the host
  logic mosi; // serial data, host to device
  logic select_low; // frame select, active low

  modport device(input sclk, input mosi, input select_low);
  modport host(output sclk, output mosi, output select_low);
endinterface

// >>> core/relay_output_device.sv
/*
  the relay output device end: serial shifter on the link clock, control
  register and periodic output refresh on the core clock.
  assumes the host keeps the link timing; the serial clock stands still
  outside frames.
*/
module relay_output_device
  import relay_link_pkg::*;
#(
  parameter int unsigned REFRESH_CYC = REFRESH_CYCLES
) (
  input wire logic core_clk, // core clock, 100 mhz
  input wire logic reset, // async reset, active high
  relay_link_if.device link, // serial link from the host
  input wire logic channel_one_force_pin, // high forces channel one on
  output logic [7:0] channel_driver // channel outputs, 1 = on
);

  // ****************************************************************
  // link clock domain
  // ****************************************************************
  typedef struct packed {
    logic [7:0] shift;
    logic [4:0] edge_gray;
  } link_state_t;

  link_state_t link_q, link_d;

  // shift only while selected, msb first, on the rising edge
  always_comb begin
    link_d = link_q;
    if (!link.select_low) begin // [RULE7]
      link_d.shift = {link_q.shift[6:0], link.mosi}; // [RULE13] [RULE14]
      link_d.edge_gray =
        bin_to_gray(gray_to_bin(link_q.edge_gray) + 5'h01); // [RULE6]
    end
  end

  always_ff @(posedge link.sclk or posedge reset) begin
    if (reset) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // ****************************************************************
  // core clock domain
  // ****************************************************************
  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic sel_prev;
    logic [4:0] gray_s1;
    logic [4:0] gray_s2;
    logic force_s1;
    logic force_s2;
    logic [4:0] frame_base;
    logic [7:0] channel_output_control;
    logic [15:0] refresh_timer;
    logic [7:0] driver;
  } core_state_t;

  core_state_t q, d;
  logic [4:0] edges_now;

  // frame end: select seen rising after exactly eight edges.
  // the shift word is read without a synchroniser: by then the link clock
  // has been still for far longer than the select crossing takes.
  always_comb begin
    d = q;
    d.sel_s1 = link.select_low;
    d.sel_s2 = q.sel_s1;
    d.sel_prev = q.sel_s2;
    d.gray_s1 = link_q.edge_gray;
    d.gray_s2 = q.gray_s1;
    d.force_s1 = channel_one_force_pin;
    d.force_s2 = q.force_s1;
    edges_now = gray_to_bin(q.gray_s2);
    if (q.sel_s2 && !q.sel_prev) begin
      if (edges_now - q.frame_base == WORD_EDGES) begin // [RULE6]
        d.channel_output_control = link_q.shift; // [RULE8] [RULE1]
      end
      d.frame_base = edges_now;
    end
    // outputs follow the control word only at the refresh tick
    if (q.refresh_timer == 16'(REFRESH_CYC - 1)) begin // [RULE3]
      d.refresh_timer = 16'h0000;
      d.driver = q.channel_output_control; // [RULE2]
      if (q.force_s2) begin
        d.driver[CHANNEL_ONE_BIT] = 1'b1; // [RULE5]
      end
    end else begin
      d.refresh_timer = q.refresh_timer + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '{sel_s1: 1'b1, sel_s2: 1'b1, sel_prev: 1'b1,
             channel_output_control: CONTROL_RESET, driver: CONTROL_RESET,
             default: '0};
    end else begin
      q <= d;
    end
  end

  assign channel_driver = q.driver;

endmodule

// >>> core/relay_link_host.sv
/*
  host end of the relay output link: an ahb-lite register slave that takes
  a word from software and sends it as one framed 8-bit serial transfer.
  assumes a single ahb-lite master, single word transfers, and a device
  that samples data on the rising serial clock.
*/
// Local design decisions: register access over AHB-Lite and the address map.
// What the document requires
// [RULE1] device keeps one 8-bit control register
// [RULE2] control bit 1 on, 0 off
// [RULE3] outputs refresh from register every 100 us
// [RULE4] pwm rewrites at twice rate, max 5 khz
// [RULE5] force pin high turns channel one on
// [RULE6] every transfer carries exactly eight bits
// [RULE7] clock and data count only while selected
// [RULE8] select release after eight bits loads register
// [RULE9] serial clock low while select is high
// [RULE10] at least 10 ns select to first rise
// [RULE11] at least 80 ns last fall to release
// [RULE12] at least 170 ns between two words
// [RULE13] most significant bit goes first
// [RULE14] sample on rise, change data while low
module relay_link_host
  import relay_link_pkg::*;
#(
  parameter int unsigned HALF_CYC = LINK_HALF_CYCLES
) (
  input wire logic core_clk, // core clock, 100 mhz
  input wire logic reset, // async reset, active high
  input wire logic hsel, // ahb slave select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  output logic [31:0] hrdata, // ahb read data
  relay_link_if.host link // serial link to the device
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [2:0] {IDLE, LEAD, HIGH, LOW, TAIL, GAP} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [7:0] timer;
    logic [2:0] bit_cnt;
    logic [7:0] word;
    logic [7:0] last_word;
    logic refused;
    logic ph_valid;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic sclk;
    logic mosi;
    logic sel_low;
  } host_state_t;

  host_state_t q, d;
  logic busy;

  // read mux used at the address phase so data stand in the data phase
  function automatic logic [31:0] read_reg(input logic [7:0] a,
                                           input host_state_t s,
                                           input logic b);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == TX_WORD_OFS) begin
      v[7:0] = s.last_word;
    end else if (a == STATUS_OFS) begin
      v[BUSY_BIT] = b;
      v[REFUSED_BIT] = s.refused;
    end
    return v;
  endfunction

  // one decode of a data-phase write, shared by every register
  function automatic logic wr_hit(input host_state_t s,
                                  input logic [7:0] a);
    return s.ph_valid && s.ph_write && s.ph_addr == a;
  endfunction

  assign busy = (q.phase != IDLE);

  // ****************************************************************
  // bus slave and serial sequencer
  // ****************************************************************
  always_comb begin
    d = q;
    // address phase capture; zero wait states
    d.ph_valid = hsel && htrans[1] && hready;
    d.ph_write = hwrite;
    d.ph_addr = {haddr[7:2], 2'b00};
    d.rdata = 32'h0000_0000;
    if (d.ph_valid && !hwrite) begin
      d.rdata = read_reg(d.ph_addr, q, busy);
    end
    // data phase of a write; clearing goes first so a new refusal wins
    if (wr_hit(q, STATUS_OFS)) begin
      if (hwdata[REFUSED_BIT]) begin
        d.refused = 1'b0;
      end
    end
    case (q.phase)
      IDLE: begin
        d.sclk = 1'b0;
        d.sel_low = 1'b1;
        if (wr_hit(q, TX_WORD_OFS)) begin
          // software sets the update rate, hence any pwm period
          d.word = hwdata[7:0]; // [RULE4]
          d.last_word = hwdata[7:0];
          d.mosi = hwdata[CHANNEL_EIGHT_BIT]; // [RULE13]
          d.sel_low = 1'b0; // [RULE7]
          d.timer = 8'h00;
          d.bit_cnt = 3'h0;
          d.phase = LEAD;
        end
      end
      LEAD: begin
        // lead covers both the first rise and first fall minimums
        if (q.timer == 8'(LEAD_CYCLES - 1)) begin // [RULE10]
          d.sclk = 1'b1; // [RULE14]
          d.timer = 8'h00;
          d.phase = HIGH;
        end else begin
          d.timer = q.timer + 8'h01;
        end
      end
      HIGH: begin
        if (q.timer == 8'(HALF_CYC - 1)) begin
          d.sclk = 1'b0;
          d.timer = 8'h00;
          if (q.bit_cnt == 3'(WORD_BITS - 1)) begin // [RULE6]
            d.phase = TAIL;
          end else begin
            d.bit_cnt = q.bit_cnt + 3'h1;
            d.phase = LOW;
          end
        end else begin
          d.timer = q.timer + 8'h01;
        end
      end
      LOW: begin
        // new bit one cycle after the fall keeps hold time on the pins
        if (q.timer == 8'h00) begin
          d.word = {q.word[6:0], 1'b0};
          d.mosi = q.word[6]; // [RULE14] [RULE13]
        end
        if (q.timer == 8'(HALF_CYC - 1)) begin
          d.sclk = 1'b1;
          d.timer = 8'h00;
          d.phase = HIGH;
        end else begin
          d.timer = q.timer + 8'h01;
        end
      end
      TAIL: begin
        if (q.timer == 8'(TAIL_CYCLES - 1)) begin // [RULE11]
          d.sel_low = 1'b1; // [RULE8]
          d.timer = 8'h00;
          d.phase = GAP;
        end else begin
          d.timer = q.timer + 8'h01;
        end
      end
      GAP: begin
        d.sclk = 1'b0; // [RULE9]
        if (q.timer == 8'(GAP_CYCLES - 1)) begin // [RULE12]
          d.timer = 8'h00;
          d.phase = IDLE;
        end else begin
          d.timer = q.timer + 8'h01;
        end
      end
      default: begin
        d.phase = IDLE;
        d.sclk = 1'b0;
        d.sel_low = 1'b1;
      end
    endcase
    // a word written while a frame runs is dropped, not queued
    if (busy && wr_hit(q, TX_WORD_OFS)) begin
      d.refused = 1'b1;
    end
  end

  // state register; reset leaves the link idle, select high, clock low
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '{phase: IDLE, sel_low: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs: link and read data from flip-flops, ready and response tied to constants
  // ****************************************************************
  // zero wait states: every transfer ends in its first data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign link.sclk = q.sclk;
  assign link.mosi = q.mosi;
  assign link.select_low = q.sel_low;

endmodule

// >>> tb/relay_link_checker.sv
/*
  wire-level assertions on the relay link between host and device.
  assumes the host drives the wires and core_clk times the host end.
*/
module relay_link_checker (
  input wire logic core_clk, // host core clock
  input wire logic reset, // async reset, active high
  input wire logic sclk, // serial clock
  input wire logic mosi, // serial data
  input wire logic select_low // frame select, active low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk_q;
  logic [4:0] rise_q;
  logic [5:0] gap_q;

  // ****************************************************************
  // helper counters
  // ****************************************************************
  // rises within a frame, idle cycles since the last frame ended
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_q <= 1'b0;
      rise_q <= 5'h00;
      gap_q <= 6'h3f;
    end else begin
      sclk_q <= sclk;
      if (select_low) rise_q <= 5'h00;
      else if (sclk && !sclk_q) rise_q <= rise_q + 5'h01;
      if (!select_low) gap_q <= 6'h00;
      else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence lead_s;
    !sclk [*8] ##1 sclk;
  endsequence
  sequence tail_s;
    !sclk [*8] ##1 $rose(select_low);
  endsequence

  a_idle_clk_low: assert property (select_low |-> !sclk)
    else $error("serial clock high outside a frame");
  a_select_lead: assert property ($fell(select_low) |-> lead_s)
    else $error("first rise not eight cycles after select");
  a_high_pulse: assert property ($rose(sclk) |-> sclk [*8])
    else $error("serial clock high pulse too short");
  a_low_pulse: assert property ($fell(sclk) |-> !sclk [*6])
    else $error("serial clock low pulse too short");
  a_tail_release: assert property
    ($fell(sclk) && rise_q == 5'h08 |-> tail_s)
    else $error("select not released eight cycles after last fall");
  a_eight_rises: assert property
    ($rose(select_low) |-> rise_q == 5'h08)
    else $error("frame does not hold eight clock rises");
  a_word_gap: assert property
    ($fell(select_low) |-> gap_q >= 6'h11)
    else $error("gap between words too short");
  a_data_steady: assert property
    ($changed(mosi) |-> !sclk && $past(sclk) == 1'b0)
    else $error("data changed while serial clock high");
endmodule

// >>> tb/tb.sv
/*
  self-checking bench: ahb master drives the host, which talks to one
  device; a second device is fed by a bench driver that breaks framing.
  assumes the host answers with zero wait states.
*/
module tb;
  import relay_link_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RCYC = 50;
  logic core_clk = 1'b0;
  logic reset, hsel, hwrite, force_pin, force_b, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, rnd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] drv, drv_b, sh, w, exp;
  logic [7:0] fixed [4] = '{8'h80, 8'h01, 8'hff, 8'h00};
  logic [7:0] wq [$];
  int err_count, n_compared;
  relay_link_if lk();
  relay_link_if bad();

  relay_link_host #(.HALF_CYC(13)) relay_link_host_inst (.core_clk(core_clk),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(lk));
  relay_output_device #(.REFRESH_CYC(RCYC)) relay_output_device_inst (
    .core_clk(core_clk), .reset(reset), .link(lk),
    .channel_one_force_pin(force_pin), .channel_driver(drv));
  relay_output_device #(.REFRESH_CYC(RCYC)) fault_relay_output_device_inst (
    .core_clk(core_clk), .reset(reset), .link(bad),
    .channel_one_force_pin(force_b), .channel_driver(drv_b));
  relay_link_checker relay_link_checker_inst (.core_clk(core_clk),
    .reset(reset), .sclk(lk.sclk), .mosi(lk.mosi),
    .select_low(lk.select_low));

  initial forever #5 core_clk = ~core_clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one ahb single transfer; hangs are cut by the watchdog
  task automatic bus(input logic wr, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  // bench-made frame at a 64 ns link period, n rises
  task automatic frame_b(input logic [7:0] v, input int n);
    #7 bad.select_low = 1'b0;
    #24;
    for (int i = 0; i < n; i++) begin
      bad.mosi = v[7 - (i % 8)];
      #8 bad.sclk = 1'b1;
      #32 bad.sclk = 1'b0;
      #24;
    end
    #80 bad.select_low = 1'b1;
    bad.mosi = ~bad.mosi;
    #200;
    repeat (2 * RCYC) @(posedge core_clk);
  endtask

  // what the device shifts in, msb first, checked at select release
  always @(posedge lk.sclk) if (!lk.select_low) sh = {sh[6:0], lk.mosi};
  always @(posedge lk.select_low) begin
    if (wq.size() != 0) check(32'(sh), 32'(wq.pop_front()));
  end

  // outputs may move only just after a refresh tick, every RCYC edges;
  // an output that followed the register at once would trip this
  int unsigned since_rel;
  logic [7:0] drv_seen;
  always @(posedge core_clk) begin
    since_rel <= reset ? 0 : since_rel + 1;
    drv_seen <= drv;
    if (!reset && drv !== drv_seen) begin
      check(32'(since_rel % RCYC), 32'h0);
    end
  end

  initial begin
    #300us;
    err_count++;
    wrap_up();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {reset, hsel, hwrite, force_pin, force_b} = 5'h10;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {bad.sclk, bad.mosi, bad.select_low} = 3'h1;
    {err_count, n_compared, rnd, sh} = {32'h0, 32'h0, 32'h6b9b, 8'h00};
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    check(32'(drv), 32'(CONTROL_RESET));
    bus(1'b0, 32'(STATUS_OFS), 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, 32'h10, 32'hff, rd);
    bus(1'b0, 32'h10, 32'h0, rd);
    check(rd, 32'h0);
    $display("test reset and map done");
    for (int i = 0; i < 10; i++) begin
      rnd = xs(rnd);
      w = (i < 4) ? fixed[i] : rnd[7:0];
      force_pin <= rnd[8];
      bus(1'b1, 32'(TX_WORD_OFS), {rnd[31:8], w}, rd);
      wq.push_back(w);
      bus(1'b1, 32'(TX_WORD_OFS), 32'h55, rd);
      bus(1'b0, 32'(STATUS_OFS), 32'h0, rd);
      check(32'(rd[1:0]), 32'h3);
      bus(1'b1, 32'(STATUS_OFS), 32'h2, rd);
      do bus(1'b0, 32'(STATUS_OFS), 32'h0, rd); while (rd[0] !== 1'b0);
      check(32'(rd[1:0]), 32'h0);
      bus(1'b0, 32'(TX_WORD_OFS), 32'h0, rd);
      check(32'(rd[7:0]), 32'(w));
      exp = w | {7'h00, force_pin};
      for (int k = 0; k < RCYC + 10 && drv !== exp; k++) @(posedge core_clk);
      check(32'(drv), 32'(exp));
      repeat (RCYC) @(posedge core_clk);
      check(32'(drv), 32'(exp));
    end
    $display("test host to device words done");
    repeat (3) begin
      #32 bad.sclk = 1'b1;
      #32 bad.sclk = 1'b0;
    end
    frame_b(8'h5a, 8);
    check(32'(drv_b), 32'h5a);
    frame_b(8'h3c, 7);
    check(32'(drv_b), 32'h5a);
    frame_b(8'hc3, 9);
    check(32'(drv_b), 32'h5a);
    $display("test faulty frames done");
    wrap_up();
  end
endmodule
